// ===== hdc_disc_side.sv
// Behavioural far-side model: disc byte handshake and control/status registers
`timescale 1ns/1ps
module hdc_disc_side (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Scenario control
  input  wire logic                          inEnable,
  input  wire logic                          outEnable,
  input  wire logic                          slow,
  // Byte handshake
  output logic                               byteRequestInN,
  output logic                               byteRequestOutN,
  input  wire logic                          byteStrobeInN,
  input  wire logic                          byteStrobeOutN,
  output logic [7:0]                         diskByteBusIn,
  input  wire logic [7:0]                    diskByteBusOut,
  input  wire logic                          diskByteBusOe,
  // Control/status bus
  input  wire logic [hdc_pkg::HDC_CS_AW-1:0] regSelectAddr,
  input  wire logic [7:0]                    ctlStatusByteBusOut,
  output logic [7:0]                         ctlStatusByteBusIn,
  input  wire logic                          csSelectN,
  input  wire logic                          csWriteStrobeN,
  input  wire logic                          csReadStrobeN
);
  logic [7:0] inIdx, outIdx;
  logic [3:0] gap;
  logic [7:0] outLog [32];
  logic [7:0] regs [64];

  // byte valid only while requested, else inverted
  assign diskByteBusIn = byteRequestInN ? ~(8'h40 + inIdx) : 8'h40 + inIdx;
  // selected register valid only while selected with read strobe, else inverted
  assign ctlStatusByteBusIn = (!csSelectN && !csReadStrobeN) ? regs[regSelectAddr]
                                                              : ~regs[regSelectAddr];

  always_ff @(posedge clk) begin
    if (!csSelectN && !csWriteStrobeN) regs[regSelectAddr] <= ctlStatusByteBusOut;
  end

  // one request per byte, dropped when strobed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byteRequestInN  <= 1'b1;
      byteRequestOutN <= 1'b1;
      inIdx           <= 8'h00;
      outIdx          <= 8'h00;
      gap             <= 4'h0;
    end else if (!byteStrobeInN) begin
      byteRequestInN <= 1'b1;
      inIdx          <= inIdx + 8'h01;
      gap            <= slow ? 4'h5 : 4'h1;
    end else if (!byteStrobeOutN) begin
      byteRequestOutN     <= 1'b1;
      outLog[outIdx[4:0]] <= diskByteBusOe ? diskByteBusOut : ~diskByteBusOut;
      outIdx              <= outIdx + 8'h01;
      gap                 <= slow ? 4'h5 : 4'h1;
    end else if (gap != 4'h0) begin
      gap <= gap - 4'h1;
    end else begin
      byteRequestInN  <= !inEnable;
      byteRequestOutN <= !outEnable;
    end
  end
endmodule

// ===== hdc_dma_ram_ctrl.sv
// Host DMA engine, shared buffer RAM and disc-side handshake
// Behaviour
// - Six-line address picks a disc-side register
// - Disc data uses separate eight-bit byte bus
// - Controller alone drives both byte strobes
// - Bus address from three switch segments
// - RAM halves each cycle between processor, engine
// - Address selector follows current RAM owner
// - Configured in or out, runs without processor
// - Processor test codes pass to display
// - Display shows two hex digits of result
// - Processor reads full, not-full, unit details
// - Processor samples both self-test pushbuttons
// - Filled buffers go out to bus interface
// - Output transfer stops when buffer empties
// - Write: one outbound strobe per request
// - Read: inbound strobe clocks requested byte in
`timescale 1ns/1ps
module hdc_dma_ram_ctrl #(
  parameter int FIFO_DEPTH = hdc_pkg::HDC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // Processor RAM port
  input  wire logic [hdc_pkg::HDC_RAM_AW-1:0]  cpuRamAddr,
  input  wire logic                            cpuRamWe,
  input  wire logic [7:0]                      cpuRamWrData,
  output logic [7:0]                           cpuRamRdData,
  output logic                                 ramOwnerDma,
  // Engine control and channel status
  input  wire logic                            dmaStart,
  input  wire hdc_pkg::hdc_dma_cfg_type        dmaCfg,
  output logic                                 dmaDone,
  input  wire logic [hdc_pkg::HDC_UNIT_W-1:0]  unitId,
  output hdc_pkg::hdc_chan_status_type         chanStatus,
  // Disc byte bus and handshake
  input  wire logic [7:0]                      diskByteBusIn,
  output logic [7:0]                           diskByteBusOut,
  output logic                                 diskByteBusOe,
  input  wire logic                            byteRequestInN,
  input  wire logic                            byteRequestOutN,
  output logic                                 byteStrobeInN,
  output logic                                 byteStrobeOutN,
  // Processor control/status access
  input  wire logic                            csReq,
  input  wire logic                            csWrite,
  input  wire logic [hdc_pkg::HDC_CS_AW-1:0]   csAddr,
  input  wire logic [7:0]                      csWrData,
  output logic [7:0]                           csRdData,
  output logic                                 csAck,
  // Control/status bus to disc side
  output logic [hdc_pkg::HDC_CS_AW-1:0]        regSelectAddr,
  input  wire logic [7:0]                      ctlStatusByteBusIn,
  output logic [7:0]                           ctlStatusByteBusOut,
  output logic                                 ctlStatusByteBusOe,
  output logic                                 csSelectN,
  output logic                                 csWriteStrobeN,
  output logic                                 csReadStrobeN,
  // Instrument-bus interface stream
  output logic [7:0]                           ibusData,
  output logic                                 ibusValid,
  input  wire logic                            ibusReady,
  // Switches and self-test display
  input  wire logic [3:0]                      addrSwitch,
  output logic [hdc_pkg::HDC_SW_ADDR_W-1:0]    busAddress,
  input  wire logic                            selfTestButton,
  input  wire logic                            showResultsButton,
  output logic                                 selfTestPressed,
  output logic                                 showResultsPressed,
  input  wire logic                            displayWrite,
  input  wire hdc_pkg::hdc_display_type        displayCode,
  output hdc_pkg::hdc_display_type             display
);
  logic [7:0]                        ram [2**hdc_pkg::HDC_RAM_AW];
  logic [hdc_pkg::HDC_RAM_AW-1:0]    ramAddr;
  logic                              ramWe;
  logic [7:0]                        ramWrData;
  logic [7:0]                        ramRdData;
  logic                              dmaPhase;
  hdc_pkg::hdc_dma_state_type        state;
  hdc_pkg::hdc_dma_cfg_type          cfg;
  logic [hdc_pkg::HDC_RAM_AW-1:0]    dmaAddr;
  logic [hdc_pkg::HDC_LEN_W-1:0]     count;
  logic [7:0]                        byteHold;
  logic                              lastByte;
  logic                              fifoInValid;
  logic                              fifoInReady;
  hdc_pkg::hdc_cs_state_type         csState;
  logic [2:0]                        csTimer;

  assign lastByte = ((count + 1'b1) == cfg.length);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dmaPhase    <= 1'b0;
      ramOwnerDma <= 1'b0;
    end else begin
      dmaPhase    <= !dmaPhase;
      ramOwnerDma <= !dmaPhase;
    end
  end

  always_comb begin
    if (dmaPhase) begin
      ramAddr   = dmaAddr;
      ramWe     = (state == hdc_pkg::HDC_STORE);
      ramWrData = byteHold;
    end else begin
      ramAddr   = cpuRamAddr;
      ramWe     = cpuRamWe;
      ramWrData = cpuRamWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (ramWe) begin
      ram[ramAddr] <= ramWrData;
    end
    ramRdData <= ram[ramAddr];
  end

  // processor read lands one cycle after its half
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpuRamRdData <= hdc_pkg::HDC_BYTE_RESET;
    end else if (dmaPhase) begin
      cpuRamRdData <= ramRdData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= hdc_pkg::HDC_IDLE;
      cfg            <= '0;
      dmaAddr        <= '0;
      count          <= '0;
      byteHold       <= hdc_pkg::HDC_BYTE_RESET;
      byteStrobeInN  <= 1'b1;
      byteStrobeOutN <= 1'b1;
      dmaDone        <= 1'b0;
    end else begin
      dmaDone        <= 1'b0;
      byteStrobeInN  <= 1'b1;
      byteStrobeOutN <= 1'b1;
      case (state)
        hdc_pkg::HDC_IDLE: begin
          if (dmaStart && dmaCfg.length != '0) begin
            cfg     <= dmaCfg;
            dmaAddr <= dmaCfg.base;
            count   <= '0;
            state   <= dmaCfg.dirIn ? hdc_pkg::HDC_WAIT : hdc_pkg::HDC_FETCH;
          end
        end
        hdc_pkg::HDC_FETCH: begin
          if (dmaPhase) begin
            state <= hdc_pkg::HDC_LOAD;
          end
        end
        hdc_pkg::HDC_LOAD: begin
          byteHold <= ramRdData;
          // buffer byte routed to the disc when toDisc, else to the bus interface
          state    <= cfg.toDisc ? hdc_pkg::HDC_WAIT : hdc_pkg::HDC_PUSH;
        end
        hdc_pkg::HDC_WAIT: begin
          if (cfg.dirIn && !byteRequestInN) begin
            byteStrobeInN <= 1'b0;
            state         <= hdc_pkg::HDC_STROBE;
          end else if (!cfg.dirIn && !byteRequestOutN) begin
            byteStrobeOutN <= 1'b0;
            state          <= hdc_pkg::HDC_STROBE;
          end
        end
        hdc_pkg::HDC_STROBE: begin
          if (cfg.dirIn) begin
            // byte taken at end of inbound strobe
            byteHold <= diskByteBusIn;
            state    <= hdc_pkg::HDC_STORE;
          end else begin
            dmaAddr <= dmaAddr + 1'b1;
            count   <= count + 1'b1;
            state   <= lastByte ? hdc_pkg::HDC_FINISH : hdc_pkg::HDC_FETCH;
          end
        end
        hdc_pkg::HDC_STORE: begin
          if (dmaPhase) begin
            dmaAddr <= dmaAddr + 1'b1;
            count   <= count + 1'b1;
            state   <= lastByte ? hdc_pkg::HDC_FINISH : hdc_pkg::HDC_WAIT;
          end
        end
        hdc_pkg::HDC_PUSH: begin
          // stops when the buffer is emptied
          if (fifoInReady) begin
            dmaAddr <= dmaAddr + 1'b1;
            count   <= count + 1'b1;
            state   <= lastByte ? hdc_pkg::HDC_FINISH : hdc_pkg::HDC_FETCH;
          end
        end
        hdc_pkg::HDC_FINISH: begin
          dmaDone <= 1'b1;
          state   <= hdc_pkg::HDC_IDLE;
        end
        default: begin
          state <= hdc_pkg::HDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diskByteBusOe <= 1'b0;
    end else begin
      diskByteBusOe <= (state != hdc_pkg::HDC_IDLE) && (state != hdc_pkg::HDC_FINISH)
                       && !cfg.dirIn && cfg.toDisc;
    end
  end
  assign diskByteBusOut = byteHold;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanStatus <= '{full: 1'b0, notFull: 1'b1, busy: 1'b0, unit: '0};
    end else begin
      chanStatus.unit <= unitId;
      chanStatus.busy <= (state != hdc_pkg::HDC_IDLE);
      if (state == hdc_pkg::HDC_IDLE && dmaStart && dmaCfg.length != '0) begin
        chanStatus.full    <= 1'b0;
        chanStatus.notFull <= 1'b1;
      end else if (state == hdc_pkg::HDC_FINISH && cfg.dirIn) begin
        // full once the count reaches length
        chanStatus.full    <= 1'b1;
        chanStatus.notFull <= 1'b0;
      end
    end
  end

  assign fifoInValid = (state == hdc_pkg::HDC_PUSH);

  hdc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) outFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (byteHold),
    .outValid (ibusValid),
    .outReady (ibusReady),
    .outData  (ibusData)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csState             <= hdc_pkg::HDC_CS_IDLE;
      csTimer             <= '0;
      regSelectAddr       <= '0;
      ctlStatusByteBusOut <= hdc_pkg::HDC_BYTE_RESET;
      ctlStatusByteBusOe  <= 1'b0;
      csSelectN           <= 1'b1;
      csWriteStrobeN      <= 1'b1;
      csReadStrobeN       <= 1'b1;
      csRdData            <= hdc_pkg::HDC_BYTE_RESET;
      csAck               <= 1'b0;
    end else begin
      csAck <= 1'b0;
      case (csState)
        hdc_pkg::HDC_CS_IDLE: begin
          if (csReq) begin
            regSelectAddr       <= csAddr;
            ctlStatusByteBusOut <= csWrData;
            ctlStatusByteBusOe  <= csWrite;
            csSelectN           <= 1'b0;
            csWriteStrobeN      <= !csWrite;
            csReadStrobeN       <= csWrite;
            csTimer             <= hdc_pkg::HDC_CS_STROBE_CYC;
            csState             <= hdc_pkg::HDC_CS_PULSE;
          end
        end
        hdc_pkg::HDC_CS_PULSE: begin
          csTimer <= csTimer - 1'b1;
          if (csTimer == 3'h1) begin
            if (!csReadStrobeN) begin
              csRdData <= ctlStatusByteBusIn;
            end
            csWriteStrobeN <= 1'b1;
            csReadStrobeN  <= 1'b1;
            csState        <= hdc_pkg::HDC_CS_DONE;
          end
        end
        hdc_pkg::HDC_CS_DONE: begin
          csSelectN          <= 1'b1;
          ctlStatusByteBusOe <= 1'b0;
          csAck              <= 1'b1;
          csState            <= hdc_pkg::HDC_CS_IDLE;
        end
        default: begin
          csState <= hdc_pkg::HDC_CS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busAddress <= '0;
    end else begin
      busAddress <= addrSwitch[hdc_pkg::HDC_SW_ADDR_LSB +: hdc_pkg::HDC_SW_ADDR_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selfTestPressed    <= 1'b0;
      showResultsPressed <= 1'b0;
    end else begin
      selfTestPressed    <= selfTestButton;
      showResultsPressed <= showResultsButton;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display <= hdc_pkg::HDC_DISPLAY_RESET;
    end else if (displayWrite) begin
      display <= displayCode;
    end
  end
endmodule

// ===== hdc_dma_ram_ctrl_bench.sv
// Self-checking testbench for the host DMA and buffer RAM controller
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module hdc_dma_ram_ctrl_bench;
  logic clk, rst, cpuRamWe, ramOwnerDma, dmaStart, dmaDone, diskByteBusOe, csReq, csWrite;
  logic byteRequestInN, byteRequestOutN, byteStrobeInN, byteStrobeOutN, csAck, ctlStatusByteBusOe;
  logic csSelectN, csWriteStrobeN, csReadStrobeN, ibusValid, ibusReady, displayWrite;
  logic selfTestButton, showResultsButton, selfTestPressed, showResultsPressed;
  logic inEnable, outEnable, slow;
  logic [hdc_pkg::HDC_RAM_AW-1:0] cpuRamAddr;
  logic [7:0] cpuRamWrData, cpuRamRdData, diskByteBusIn, diskByteBusOut, rd;
  logic [7:0] csWrData, csRdData, ctlStatusByteBusIn, ctlStatusByteBusOut, ibusData;
  logic [hdc_pkg::HDC_CS_AW-1:0] csAddr, regSelectAddr;
  logic [3:0] unitId, addrSwitch;
  logic [2:0] busAddress;
  hdc_pkg::hdc_dma_cfg_type dmaCfg;
  hdc_pkg::hdc_chan_status_type chanStatus;
  hdc_pkg::hdc_display_type displayCode, display;
  int fails, nTests;

  hdc_dma_ram_ctrl #(.FIFO_DEPTH(16)) uut (
    .clk, .rst, .cpuRamAddr, .cpuRamWe, .cpuRamWrData, .cpuRamRdData, .ramOwnerDma,
    .dmaStart, .dmaCfg, .dmaDone, .unitId, .chanStatus, .diskByteBusIn, .diskByteBusOut,
    .diskByteBusOe, .byteRequestInN, .byteRequestOutN, .byteStrobeInN, .byteStrobeOutN,
    .csReq, .csWrite, .csAddr, .csWrData, .csRdData, .csAck, .regSelectAddr,
    .ctlStatusByteBusIn, .ctlStatusByteBusOut, .ctlStatusByteBusOe, .csSelectN,
    .csWriteStrobeN, .csReadStrobeN, .ibusData, .ibusValid, .ibusReady, .addrSwitch,
    .busAddress, .selfTestButton, .showResultsButton, .selfTestPressed,
    .showResultsPressed, .displayWrite, .displayCode, .display);
  hdc_disc_side disc (
    .clk, .rst, .inEnable, .outEnable, .slow, .byteRequestInN, .byteRequestOutN, .diskByteBusOe,
    .byteStrobeInN, .byteStrobeOutN, .diskByteBusIn, .diskByteBusOut, .regSelectAddr,
    .ctlStatusByteBusOut, .ctlStatusByteBusIn, .csSelectN, .csWriteStrobeN, .csReadStrobeN);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cpuWrite(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    cpuRamAddr = a; cpuRamWrData = d; cpuRamWe = 1'b1;
    repeat (2) @(negedge clk);
    cpuRamWe = 1'b0;
  endtask

  task automatic cpuRead(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    cpuRamAddr = a;
    repeat (4) @(negedge clk);
    d = cpuRamRdData;
  endtask

  task automatic startDma(input hdc_pkg::hdc_dma_cfg_type c);
    @(negedge clk);
    dmaCfg = c; dmaStart = 1'b1;
    @(negedge clk);
    dmaStart = 1'b0;
  endtask

  task automatic waitDone();
    int i;
    for (i = 0; i < 3000 && dmaDone !== 1'b1; i++) @(negedge clk);
    if (dmaDone !== 1'b1) begin fails++; stopTest(); end
  endtask

  task automatic csXfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    int i;
    @(negedge clk);
    csWrite = w; csAddr = a; csWrData = d; csReq = 1'b1;
    @(negedge clk);
    csReq = 1'b0;
    for (i = 0; i < 20 && csAck !== 1'b1; i++) @(negedge clk);
    if (csAck !== 1'b1) begin fails++; stopTest(); end
    rd = csRdData;
  endtask

  task automatic checkReset();
    `CHECK("strobes", 2'b11, {byteStrobeInN, byteStrobeOutN})
    `CHECK("oe", 1'b0, diskByteBusOe)
    `CHECK("display", 8'h00, display)
    `CHECK("status", 3'b010, {chanStatus.full, chanStatus.notFull, chanStatus.busy})
    `CHECK("ibusValid", 1'b0, ibusValid)
  endtask

  task automatic checkPins();
    for (int s = 0; s < 16; s++) begin
      @(negedge clk);
      addrSwitch = 4'(s); selfTestButton = s[0]; showResultsButton = s[1]; unitId = 4'(s);
      repeat (2) @(negedge clk);
      `CHECK("busAddress", 3'(s), busAddress)
      `CHECK("buttons", 2'(s), {showResultsPressed, selfTestPressed})
      `CHECK("unit", 4'(s), chanStatus.unit)
    end
    displayCode = 8'hA5; displayWrite = 1'b1;
    @(negedge clk);
    displayWrite = 1'b0; displayCode = 8'h3C;
    @(negedge clk);
    `CHECK("display", 8'hA5, display)
  endtask

  task automatic ibusStall();
    int k;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 20; i++) cpuWrite(12'h200 + 12'(i), 8'h30 + 8'(i));
    startDma('{1'b0, 1'b0, 12'h200, 13'h0014});
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      seen = seen | (dmaDone === 1'b1);
    end
    `CHECK("stalled done", 1'b0, seen)
    `CHECK("stalled busy", 1'b1, chanStatus.busy)
    ibusReady = 1'b1;
    k = 0;
    for (int i = 0; i < 400 && (k < 20 || !seen); i++) begin
      seen = seen | (dmaDone === 1'b1);
      if (ibusValid === 1'b1) begin
        `CHECK("ibusData", 8'h30 + 8'(k), ibusData)
        k++;
      end
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    `CHECK("ibus count", 20, k)
    `CHECK("ibus done", 1'b1, seen)
    `CHECK("ibus empty", 1'b0, ibusValid)
  endtask

  task automatic discOut();
    slow = 1'b1; outEnable = 1'b1;
    startDma('{1'b0, 1'b1, 12'h202, 13'h0005});
    waitDone();
    outEnable = 1'b0;
    repeat (8) @(negedge clk);
    `CHECK("out count", 8'h05, disc.outIdx)
    for (int i = 0; i < 5; i++) `CHECK("out byte", 8'h32 + 8'(i), disc.outLog[i])
  endtask

  task automatic discIn();
    cpuWrite(12'h300, 8'hEE);
    slow = 1'b0; inEnable = 1'b1;
    startDma('{1'b1, 1'b0, 12'h100, 13'h0006});
    repeat (6) @(negedge clk);
    startDma('{1'b1, 1'b0, 12'h300, 13'h0003});
    waitDone();
    inEnable = 1'b0;
    repeat (8) @(negedge clk);
    `CHECK("in count", 8'h06, disc.inIdx)
    `CHECK("full", 2'b10, {chanStatus.full, chanStatus.notFull})
    for (int i = 0; i < 6; i++) begin
      cpuRead(12'h100 + 12'(i), rd);
      `CHECK("in byte", 8'h40 + 8'(i), rd)
    end
    cpuRead(12'h300, rd);
    `CHECK("refused start", 8'hEE, rd)
  endtask

  task automatic csAccess();
    csXfer(1'b1, 6'h2A, 8'hC3);
    `CHECK("cs reg", 8'hC3, disc.regs[42])
    csXfer(1'b0, 6'h2A, 8'h00);
    `CHECK("cs read", 8'hC3, rd)
  endtask

  initial begin
    fails = 0; nTests = 0; rst = 1'b1;
    cpuRamAddr = 12'h000; cpuRamWe = 1'b0; cpuRamWrData = 8'h00;
    dmaStart = 1'b0; dmaCfg = '0; unitId = 4'h0; ibusReady = 1'b0;
    csReq = 1'b0; csWrite = 1'b0; csAddr = 6'h00; csWrData = 8'h00;
    addrSwitch = 4'h0; selfTestButton = 1'b0; showResultsButton = 1'b0;
    displayWrite = 1'b0; displayCode = 8'h00;
    inEnable = 1'b0; outEnable = 1'b0; slow = 1'b0;
    repeat (5) @(negedge clk);
    checkReset();
    rst = 1'b0;
    checkPins();
    ibusStall();
    discOut();
    discIn();
    csAccess();
    stopTest();
  end
endmodule

bind hdc_dma_ram_ctrl hdc_dma_ram_ctrl_sva chk (
  .clk, .rst, .ramOwnerDma, .dmaStart, .dmaCfg, .chanStatus, .diskByteBusOut,
  .diskByteBusOe, .byteRequestInN, .byteRequestOutN, .byteStrobeInN, .byteStrobeOutN,
  .csSelectN, .csWriteStrobeN, .csAck, .ctlStatusByteBusOe, .addrSwitch, .busAddress,
  .selfTestButton, .showResultsButton, .selfTestPressed, .showResultsPressed,
  .displayWrite, .displayCode, .display);

// ===== hdc_dma_ram_ctrl_sva.sv
// Port-level checker for the host DMA and buffer RAM controller
`timescale 1ns/1ps
module hdc_dma_ram_ctrl_sva (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Watched ports
  input  wire logic                          ramOwnerDma,
  input  wire logic                          dmaStart,
  input  wire hdc_pkg::hdc_dma_cfg_type      dmaCfg,
  input  wire hdc_pkg::hdc_chan_status_type  chanStatus,
  input  wire logic [7:0]                    diskByteBusOut,
  input  wire logic                          diskByteBusOe,
  input  wire logic                          byteRequestInN,
  input  wire logic                          byteRequestOutN,
  input  wire logic                          byteStrobeInN,
  input  wire logic                          byteStrobeOutN,
  input  wire logic                          csSelectN,
  input  wire logic                          csWriteStrobeN,
  input  wire logic                          csAck,
  input  wire logic                          ctlStatusByteBusOe,
  input  wire logic [3:0]                    addrSwitch,
  input  wire logic [hdc_pkg::HDC_SW_ADDR_W-1:0] busAddress,
  input  wire logic                          selfTestButton,
  input  wire logic                          showResultsButton,
  input  wire logic                          selfTestPressed,
  input  wire logic                          showResultsPressed,
  input  wire logic                          displayWrite,
  input  wire hdc_pkg::hdc_display_type      displayCode,
  input  wire hdc_pkg::hdc_display_type      display
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_strobe_in_req: assert property (
    !byteStrobeInN |-> !$past(byteRequestInN)) else $error("inbound strobe without request");
  a_strobe_out_req: assert property (
    !byteStrobeOutN |-> !$past(byteRequestOutN)) else $error("outbound strobe without request");
  a_strobe_one_cycle: assert property (
    $fell(byteStrobeInN) |=> byteStrobeInN) else $error("inbound strobe too long");
  a_strobes_apart: assert property (
    !(!byteStrobeInN && !byteStrobeOutN)) else $error("both strobes low");
  a_out_byte_held: assert property (
    !byteStrobeOutN |-> diskByteBusOe && $stable(diskByteBusOut))
    else $error("byte bus not held during strobe");
  a_bus_addr_map: assert property (
    !$past(rst) |-> busAddress == 3'($past(addrSwitch))) else $error("bus address wrong");
  a_owner_toggles: assert property (
    !$past(rst) |-> ramOwnerDma != $past(ramOwnerDma)) else $error("RAM owner did not alternate");
  a_display_load: assert property (
    displayWrite |=> display == $past(displayCode)) else $error("display not loaded");
  a_button_copy: assert property (
    !$past(rst) |-> selfTestPressed == $past(selfTestButton)
      && showResultsPressed == $past(showResultsButton)) else $error("button copy wrong");
  a_full_excl: assert property (
    chanStatus.full |-> !chanStatus.notFull) else $error("full and not-full together");
  a_cs_write_seq: assert property (
    $fell(csWriteStrobeN) |-> !csSelectN && ctlStatusByteBusOe ##1 !csWriteStrobeN
      ##1 csWriteStrobeN && !csSelectN ##1 csSelectN && csAck) else $error("cs write cycle wrong");
  a_start_busy: assert property (
    dmaStart && !chanStatus.busy && dmaCfg.length != 13'h0000 |-> ##[2:3] chanStatus.busy)
    else $error("engine did not start");
endmodule

// ===== hdc_fifo.sv
// Parameterised FIFO with registered output stage
`timescale 1ns/1ps
module hdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = (count != '0) && (!outValid || outReady);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output stage refills as soon as it empties or is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule

// ===== hdc_pkg.sv
// Shared constants and types for the host DMA and buffer RAM controller
package hdc_pkg;

  // Widths of the buses and the buffer RAM
  localparam int HDC_BYTE_W     = 8;
  localparam int HDC_RAM_AW     = 12;
  localparam int HDC_LEN_W      = 13;
  localparam int HDC_CS_AW      = 6;
  localparam int HDC_FIFO_DEPTH = 16;
  localparam int HDC_UNIT_W     = 4;

  // Address switch: three live segments at the bottom
  localparam int HDC_SW_ADDR_LSB = 0;
  localparam int HDC_SW_ADDR_W   = 3;

  // Reset values
  localparam logic [7:0] HDC_DISPLAY_RESET = 8'h00;
  localparam logic [7:0] HDC_BYTE_RESET    = 8'h00;

  // Control/status strobe: time in ns and derived cycles at 100 MHz
  localparam int         HDC_CLK_PERIOD_NS  = 10;
  localparam int         HDC_CS_STROBE_NS   = 20;
  localparam logic [2:0] HDC_CS_STROBE_CYC  =
    3'((HDC_CS_STROBE_NS + HDC_CLK_PERIOD_NS - 1) / HDC_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    HDC_IDLE   = 3'h0,
    HDC_FETCH  = 3'h1,
    HDC_LOAD   = 3'h3,
    HDC_WAIT   = 3'h2,
    HDC_STROBE = 3'h6,
    HDC_STORE  = 3'h7,
    HDC_PUSH   = 3'h5,
    HDC_FINISH = 3'h4
  } hdc_dma_state_type;

  typedef enum logic [1:0] {
    HDC_CS_IDLE  = 2'h0,
    HDC_CS_PULSE = 2'h1,
    HDC_CS_DONE  = 2'h3
  } hdc_cs_state_type;

  // Transfer set-up given by the processor at start
  typedef struct packed {
    logic                  dirIn;
    logic                  toDisc;
    logic [HDC_RAM_AW-1:0] base;
    logic [HDC_LEN_W-1:0]  length;
  } hdc_dma_cfg_type;

  // Channel status seen by the processor
  typedef struct packed {
    logic                  full;
    logic                  notFull;
    logic                  busy;
    logic [HDC_UNIT_W-1:0] unit;
  } hdc_chan_status_type;

  // Two hex digits: unit/assembly and subtest number
  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } hdc_display_type;

endpackage
